// *** core/hcp_pkg.sv ***
// Shared constants and types for the host processor configuration port
package hcp_pkg;
   localparam int ADDR_W      = 18;
   localparam int ADDR_MSB    = 31;
   localparam int ADDR_LSB    = 14;
   localparam int DATA_W_MAX  = 16;
   localparam int PAR_W_MAX   = 3;
   localparam int SB_DATA_W   = 32;
   localparam int SB_PAR_W    = 4;
   localparam int SYNC_STAGES = 2;
   localparam logic [1:0] RESP_ACK   = 2'h0;
   localparam logic [1:0] RESP_ERR   = 2'h1;
   localparam logic [1:0] RESP_RETRY = 2'h2;
   localparam logic [1:0] PORT_DEDICATED = 2'h0;
   localparam logic [1:0] PORT_SERIAL    = 2'h1;
   localparam logic [1:0] PORT_HOST      = 2'h2;
   localparam logic [2:0] HOST_CLK_DIV   = 3'h4;
   typedef enum logic [1:0] {
      HCP_CFG_NONE,
      HCP_CFG_DEDICATED,
      HCP_CFG_SERIAL,
      HCP_CFG_HOST
   } hcp_cfg_port_e;
endpackage

// *** core/hcp_link_if.sv ***
// Interface joining the bus master end and the host port end
`timescale 1ns/1ps
`default_nettype none
interface hcp_link_if;
   logic                                 host_bus_clock;
   logic                                 transfer_start_n;
   logic                                 write_not_read;
   logic [hcp_pkg::ADDR_W-1:0]           host_addr_in;
   logic [hcp_pkg::DATA_W_MAX-1:0]       data_m2d;
   logic                                 data_m2d_oe;
   logic [hcp_pkg::DATA_W_MAX-1:0]       data_d2m;
   logic                                 data_d2m_oe;
   logic [hcp_pkg::PAR_W_MAX-1:0]        par_m2d;
   logic [hcp_pkg::PAR_W_MAX-1:0]        par_d2m;
   logic                                 transfer_ack_n;
   logic                                 transfer_error_ack_n;
   logic                                 transfer_retry_n;
   wire  [hcp_pkg::DATA_W_MAX-1:0]       host_data_bus;
   wire  [hcp_pkg::PAR_W_MAX-1:0]        host_parity_bus;
   assign host_data_bus   = data_d2m_oe ? data_d2m : data_m2d;
   assign host_parity_bus = data_d2m_oe ? par_d2m : par_m2d;
   modport master (
      output host_bus_clock, transfer_start_n, write_not_read, host_addr_in,
      output data_m2d, data_m2d_oe, par_m2d,
      input  host_data_bus, host_parity_bus,
      input  transfer_ack_n, transfer_error_ack_n, transfer_retry_n
   );
   modport device (
      input  host_bus_clock, transfer_start_n, write_not_read, host_addr_in,
      input  host_data_bus, host_parity_bus,
      output data_d2m, data_d2m_oe, par_d2m,
      output transfer_ack_n, transfer_error_ack_n, transfer_retry_n
   );
endinterface
`default_nettype wire

// *** core/hcp_device_port.sv ***
// Device end: configuration port selection and host processor bus slave
//
// Summary of operation
// - Three config ports: serial, dedicated, host.
// - Serial port speaks boundary-scan and ISC protocols.
// - Dedicated port pins freed when unused.
// - After power-up, dedicated port active by default.
// - Serial config instruction switches mode only while unlocked.
// - Selected port locks until re-initialization.
// - Host waits for a response low before next strobe.
// - Address captured on edge after strobe low.
// - 18-bit address carries master bits 31..14.
// - Data 8/16 bits; master drives it on writes, device on reads.
// - Parity bit per byte lane, up to three.
// - Acknowledge low on accepted or returned data.
// - Error acknowledge low on system bus error.
// - Retry low asks master to retry later.
// - Forward onto 32-bit system bus with 4 parity.
`timescale 1ns/1ps
`default_nettype none
module hcp_device_port #(
   parameter int DATA_W = 16,                          // Host data width, 8 or 16
   parameter int PAR_W  = 2                            // Host parity width, 1 to 3
) (
   input  wire logic                              core_clk_in,        // Core clock
   input  wire logic                              reset_n_in,         // Async reset, low
   hcp_link_if.device                             link,               // Host bus side
   input  wire logic                              reinit_in,          // Re-initialization pulse
   input  wire logic                              serial_cfg_cmd_in,  // Serial config instruction
   input  wire logic                              dedicated_start_in, // Dedicated port activity
   output logic                                   dual_pins_gpio_out, // Dual-use pins free
   output logic [1:0]                             active_port_out,    // Selected config port
   output logic                                   port_locked_out,    // Selection locked
   output logic                                   sb_req_out,         // System bus request
   output logic                                   sb_write_out,       // System bus write
   output logic [hcp_pkg::ADDR_W-1:0]             sb_addr_out,        // System bus address
   output logic [hcp_pkg::SB_DATA_W-1:0]          sb_wdata_out,       // System bus write data
   output logic [hcp_pkg::SB_PAR_W-1:0]           sb_wpar_out,        // System bus write parity
   input  wire logic                              sb_done_in,         // System bus done
   input  wire logic                              sb_err_in,          // System bus error
   input  wire logic                              sb_busy_in,         // System bus busy, retry
   input  wire logic [hcp_pkg::SB_DATA_W-1:0]     sb_rdata_in,        // System bus read data
   input  wire logic [hcp_pkg::SB_PAR_W-1:0]      sb_rpar_in          // System bus read parity
);
   initial begin
      if (!(DATA_W == 8 || DATA_W == 16) || PAR_W < 1 || PAR_W > hcp_pkg::PAR_W_MAX)
         $error("hcp_device_port: unsupported width");
   end

   // ============================================================
   // Synchronisers
   logic [hcp_pkg::SYNC_STAGES-1:0] clk_s_q, clk_s_d;
   logic [hcp_pkg::SYNC_STAGES-1:0] strb_s_q, strb_s_d;
   logic                            clk_prev_q, clk_prev_d;
   logic                            host_rise;

   always_comb begin
      clk_s_d    = {clk_s_q[0], link.host_bus_clock};
      strb_s_d   = {strb_s_q[0], link.transfer_start_n};
      clk_prev_d = clk_s_q[1];
   end

   always_ff @(posedge core_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         clk_s_q    <= '1;
         strb_s_q   <= '1;
         clk_prev_q <= 1'b1;
      end else begin
         clk_s_q    <= clk_s_d;
         strb_s_q   <= strb_s_d;
         clk_prev_q <= clk_prev_d;
      end
   end

   assign host_rise = clk_s_q[1] & ~clk_prev_q;

   // ============================================================
   // Configuration port selection
   hcp_pkg::hcp_cfg_port_e cfg_q, cfg_d;
   logic                   lock_q, lock_d;
   logic [1:0]             port_q, port_d;
   logic                   host_start;

   always_comb begin
      cfg_d  = cfg_q;
      lock_d = lock_q;
      if (reinit_in) begin
         cfg_d  = hcp_pkg::HCP_CFG_DEDICATED;
         lock_d = 1'b0;
      end else if (!lock_q) begin
         if (serial_cfg_cmd_in) begin
            cfg_d  = hcp_pkg::HCP_CFG_SERIAL;
            lock_d = 1'b1;
         end else if (host_start) begin
            cfg_d  = hcp_pkg::HCP_CFG_HOST;
            lock_d = 1'b1;
         end else if (dedicated_start_in) begin
            cfg_d  = hcp_pkg::HCP_CFG_DEDICATED;
            lock_d = 1'b1;
         end
      end
      port_d = cfg_d == hcp_pkg::HCP_CFG_SERIAL ? hcp_pkg::PORT_SERIAL :
               cfg_d == hcp_pkg::HCP_CFG_HOST   ? hcp_pkg::PORT_HOST   :
                                                  hcp_pkg::PORT_DEDICATED;
   end

   always_ff @(posedge core_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         cfg_q  <= hcp_pkg::HCP_CFG_DEDICATED;
         lock_q <= 1'b0;
         port_q <= hcp_pkg::PORT_DEDICATED;
      end else begin
         cfg_q  <= cfg_d;
         lock_q <= lock_d;
         port_q <= port_d;
      end
   end

   // ============================================================
   // Host bus slave
   typedef enum logic [2:0] {HCP_IDLE, HCP_SB, HCP_RESP, HCP_END} hcp_st_e;
   hcp_st_e                        st_q, st_d;
   logic [hcp_pkg::ADDR_W-1:0]     addr_q, addr_d;
   logic                           wr_q, wr_d;
   logic [hcp_pkg::SB_DATA_W-1:0]  wdat_q, wdat_d;
   logic [hcp_pkg::SB_PAR_W-1:0]   wpar_q, wpar_d;
   logic [DATA_W-1:0]              rdat_q, rdat_d;
   logic [PAR_W-1:0]               rpar_q, rpar_d;
   logic [1:0]                     resp_q, resp_d;
   logic                           req_q, req_d;
   logic                           ta_q, ta_d, tea_q, tea_d, rty_q, rty_d;
   logic                           oe_q, oe_d;
   logic                           gpio_q, gpio_d;
   logic                           host_ok;

   assign host_ok    = !lock_q || cfg_q == hcp_pkg::HCP_CFG_HOST;
   assign host_start = st_q == HCP_IDLE && host_rise && !strb_s_q[1] && !reinit_in;

   always_comb begin
      st_d   = st_q;
      addr_d = addr_q;
      wr_d   = wr_q;
      wdat_d = wdat_q;
      wpar_d = wpar_q;
      rdat_d = rdat_q;
      rpar_d = rpar_q;
      resp_d = resp_q;
      req_d  = 1'b0;
      ta_d   = ta_q;
      tea_d  = tea_q;
      rty_d  = rty_q;
      oe_d   = oe_q;
      gpio_d = cfg_q != hcp_pkg::HCP_CFG_DEDICATED;
      unique case (st_q)
         HCP_IDLE: begin
            if (host_rise && !strb_s_q[1]) begin
               addr_d = link.host_addr_in;
               wr_d   = link.write_not_read;
               wdat_d = '0;
               wpar_d = '0;
               wdat_d[DATA_W-1:0] = link.host_data_bus[DATA_W-1:0];
               wpar_d[PAR_W-1:0]  = link.host_parity_bus[PAR_W-1:0];
               if (!host_ok) begin
                  resp_d = hcp_pkg::RESP_RETRY;
                  st_d   = HCP_RESP;
               end else begin
                  req_d = 1'b1;
                  st_d  = HCP_SB;
               end
            end
         end
         HCP_SB: begin
            if (sb_done_in || sb_err_in || sb_busy_in) begin
               resp_d = sb_err_in  ? hcp_pkg::RESP_ERR   :
                        sb_busy_in ? hcp_pkg::RESP_RETRY :
                                     hcp_pkg::RESP_ACK;
               rdat_d = sb_rdata_in[DATA_W-1:0];
               rpar_d = sb_rpar_in[PAR_W-1:0];
               st_d   = HCP_RESP;
            end
         end
         HCP_RESP: begin
            if (host_rise) begin
               ta_d  = resp_q != hcp_pkg::RESP_ACK;
               tea_d = resp_q != hcp_pkg::RESP_ERR;
               rty_d = resp_q != hcp_pkg::RESP_RETRY;
               oe_d  = !wr_q && resp_q == hcp_pkg::RESP_ACK;
               st_d  = HCP_END;
            end
         end
         HCP_END: begin
            if (host_rise) begin
               ta_d  = 1'b1;
               tea_d = 1'b1;
               rty_d = 1'b1;
               oe_d  = 1'b0;
               st_d  = HCP_IDLE;
            end
         end
         default: st_d = HCP_IDLE;
      endcase
   end

   always_ff @(posedge core_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         st_q   <= HCP_IDLE;
         addr_q <= '0;
         wr_q   <= 1'b0;
         wdat_q <= '0;
         wpar_q <= '0;
         rdat_q <= '0;
         rpar_q <= '0;
         resp_q <= hcp_pkg::RESP_ACK;
         req_q  <= 1'b0;
         ta_q   <= 1'b1;
         tea_q  <= 1'b1;
         rty_q  <= 1'b1;
         oe_q   <= 1'b0;
         gpio_q <= 1'b0;
      end else begin
         st_q   <= st_d;
         addr_q <= addr_d;
         wr_q   <= wr_d;
         wdat_q <= wdat_d;
         wpar_q <= wpar_d;
         rdat_q <= rdat_d;
         rpar_q <= rpar_d;
         resp_q <= resp_d;
         req_q  <= req_d;
         ta_q   <= ta_d;
         tea_q  <= tea_d;
         rty_q  <= rty_d;
         oe_q   <= oe_d;
         gpio_q <= gpio_d;
      end
   end

   // ============================================================
   // Outputs
   always_comb begin
      link.data_d2m = '0;
      link.par_d2m  = '0;
      link.data_d2m[DATA_W-1:0] = rdat_q;
      link.par_d2m[PAR_W-1:0]   = rpar_q;
   end
   assign link.data_d2m_oe          = oe_q;
   assign link.transfer_ack_n       = ta_q;
   assign link.transfer_error_ack_n = tea_q;
   assign link.transfer_retry_n     = rty_q;
   assign dual_pins_gpio_out        = gpio_q;
   assign active_port_out           = port_q;
   assign port_locked_out           = lock_q;
   assign sb_req_out                = req_q;
   assign sb_write_out              = wr_q;
   assign sb_addr_out               = addr_q;
   assign sb_wdata_out              = wdat_q;
   assign sb_wpar_out               = wpar_q;
endmodule
`default_nettype wire

// *** core/hcp_master_port.sv ***
// Master end: drives host bus transfers and derives the host bus clock
`timescale 1ns/1ps
`default_nettype none
module hcp_master_port #(
   parameter int DATA_W = 16,                         // Host data width, 8 or 16
   parameter int PAR_W  = 2                           // Host parity width, 1 to 3
) (
   input  wire logic                           core_clk_in,   // Core clock
   input  wire logic                           reset_n_in,    // Async reset, low
   hcp_link_if.master                          link,          // Host bus side
   input  wire logic                           req_in,        // Transfer request pulse
   input  wire logic                           write_in,      // 1 write, 0 read
   input  wire logic [31:0]                    addr_in,       // Full 32-bit address
   input  wire logic [DATA_W-1:0]              wdata_in,      // Write data
   output logic                                busy_out,      // Transfer in progress
   output logic                                done_out,      // Completion pulse
   output logic [1:0]                          resp_out,      // Response code
   output logic [DATA_W-1:0]                   rdata_out,     // Read data
   output logic                                par_ok_out     // Read parity good
);
   initial begin
      if (!(DATA_W == 8 || DATA_W == 16) || PAR_W < 1 || PAR_W > hcp_pkg::PAR_W_MAX)
         $error("hcp_master_port: unsupported width");
   end

   // ============================================================
   // Clock divider and response sampling
   typedef enum logic [1:0] {HCM_IDLE, HCM_STRB, HCM_WAIT} hcm_st_e;
   hcm_st_e           st_q, st_d;
   logic [2:0]        div_q, div_d;
   logic              hclk_q, hclk_d;
   logic              rise;
   logic              strb_q, strb_d, wr_q, wr_d, oe_q, oe_d;
   logic [hcp_pkg::ADDR_W-1:0] a_q, a_d;
   logic [DATA_W-1:0] wd_q, wd_d, rd_q, rd_d;
   logic [PAR_W-1:0]  wp;
   logic              busy_q, busy_d, done_q, done_d, pok_q, pok_d;
   logic [1:0]        resp_q, resp_d;
   logic              pend_q, pend_d;

   assign rise = div_q == hcp_pkg::HOST_CLK_DIV - 3'h1 && !hclk_q;

   always_comb begin
      for (int i = 0; i < PAR_W; i++) begin
         wp[i] = (8 * i < DATA_W) ? ^wdata_in[8*i +: 8] : 1'b0;
      end
   end

   always_comb begin
      div_d  = div_q == hcp_pkg::HOST_CLK_DIV - 3'h1 ? 3'h0 : div_q + 3'h1;
      hclk_d = div_q == hcp_pkg::HOST_CLK_DIV - 3'h1 ? ~hclk_q : hclk_q;
      st_d   = st_q;
      strb_d = strb_q;
      wr_d   = wr_q;
      oe_d   = oe_q;
      a_d    = a_q;
      wd_d   = wd_q;
      rd_d   = rd_q;
      busy_d = busy_q;
      done_d = 1'b0;
      pok_d  = pok_q;
      resp_d = resp_q;
      pend_d = pend_q;
      unique case (st_q)
         HCM_IDLE: begin
            if (req_in) begin
               a_d    = addr_in[hcp_pkg::ADDR_MSB:hcp_pkg::ADDR_LSB];
               wr_d   = write_in;
               wd_d   = wdata_in;
               busy_d = 1'b1;
               pend_d = 1'b1;
            end
            if (pend_q && hclk_q && div_q == 3'h0) begin
               strb_d = 1'b0;
               oe_d   = wr_q;
               pend_d = 1'b0;
               st_d   = HCM_STRB;
            end
         end
         HCM_STRB: begin
            // Release one core cycle after the host clock rise so the far end samples it low
            if (hclk_q && div_q == 3'h0) begin
               strb_d = 1'b1;
               st_d   = HCM_WAIT;
            end
         end
         HCM_WAIT: begin
            if (rise && (!link.transfer_ack_n || !link.transfer_error_ack_n
                         || !link.transfer_retry_n)) begin
               resp_d = !link.transfer_error_ack_n ? hcp_pkg::RESP_ERR   :
                        !link.transfer_retry_n     ? hcp_pkg::RESP_RETRY :
                                                     hcp_pkg::RESP_ACK;
               rd_d   = link.host_data_bus[DATA_W-1:0];
               pok_d  = 1'b1;
               for (int i = 0; i < PAR_W; i++) begin
                  if (8 * i < DATA_W && link.host_parity_bus[i] != ^link.host_data_bus[8*i +: 8])
                     pok_d = 1'b0;
               end
               oe_d   = 1'b0;
               busy_d = 1'b0;
               done_d = 1'b1;
               st_d   = HCM_IDLE;
            end
         end
         default: st_d = HCM_IDLE;
      endcase
   end

   always_ff @(posedge core_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         st_q   <= HCM_IDLE;
         div_q  <= 3'h0;
         hclk_q <= 1'b0;
         strb_q <= 1'b1;
         wr_q   <= 1'b0;
         oe_q   <= 1'b0;
         a_q    <= '0;
         wd_q   <= '0;
         rd_q   <= '0;
         busy_q <= 1'b0;
         done_q <= 1'b0;
         pok_q  <= 1'b1;
         resp_q <= hcp_pkg::RESP_ACK;
         pend_q <= 1'b0;
      end else begin
         st_q   <= st_d;
         div_q  <= div_d;
         hclk_q <= hclk_d;
         strb_q <= strb_d;
         wr_q   <= wr_d;
         oe_q   <= oe_d;
         a_q    <= a_d;
         wd_q   <= wd_d;
         rd_q   <= rd_d;
         busy_q <= busy_d;
         done_q <= done_d;
         pok_q  <= pok_d;
         resp_q <= resp_d;
         pend_q <= pend_d;
      end
   end

   // ============================================================
   // Outputs
   logic [PAR_W-1:0] wp_q;
   always_ff @(posedge core_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         wp_q <= '0;
      end else if (req_in && st_q == HCM_IDLE) begin
         wp_q <= wp;
      end
   end

   always_comb begin
      link.data_m2d = '0;
      link.par_m2d  = '0;
      link.data_m2d[DATA_W-1:0] = wd_q;
      link.par_m2d[PAR_W-1:0]   = wp_q;
   end
   assign link.host_bus_clock   = hclk_q;
   assign link.transfer_start_n = strb_q;
   assign link.write_not_read   = wr_q;
   assign link.host_addr_in     = a_q;
   assign link.data_m2d_oe      = oe_q;
   assign busy_out              = busy_q;
   assign done_out              = done_q;
   assign resp_out              = resp_q;
   assign rdata_out             = rd_q;
   assign par_ok_out            = pok_q;
endmodule
`default_nettype wire

// *** dv/hcp_link_chk.sv ***
// Concurrent checks on the host port link between master and device ends
`timescale 1ns/1ps
`default_nettype none
module hcp_link_chk (
   input wire logic                       core_clk_in,          // Core clock
   input wire logic                       reset_n_in,           // Async reset, low
   input wire logic                       transfer_start_n,     // Transfer strobe
   input wire logic [hcp_pkg::ADDR_W-1:0] host_addr_in,         // Host address
   input wire logic                       data_m2d_oe,          // Master drives data
   input wire logic                       data_d2m_oe,          // Device drives data
   input wire logic                       transfer_ack_n,       // Acknowledge
   input wire logic                       transfer_error_ack_n, // Error acknowledge
   input wire logic                       transfer_retry_n      // Retry
);
   logic resp_low;
   logic pend_q;
   logic pend_d;
   assign resp_low = !(transfer_ack_n && transfer_error_ack_n && transfer_retry_n);
   // =========================================
   // Outstanding transfer tracker
   always_comb begin
      pend_d = pend_q;
      if (resp_low) begin
         pend_d = 1'b0;
      end else if (!transfer_start_n) begin
         pend_d = 1'b1;
      end
   end
   always_ff @(posedge core_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         pend_q <= 1'b0;
      end else begin
         pend_q <= pend_d;
      end
   end
   // =========================================
   // Properties
   default clocking cb @(posedge core_clk_in); endclocking
   default disable iff (!reset_n_in);
   property p_one_resp;
      $onehot0({!transfer_ack_n, !transfer_error_ack_n, !transfer_retry_n});
   endproperty
   property p_resp_len;
      $rose(resp_low) |-> resp_low[*8] ##1 !resp_low;
   endproperty
   property p_resp_cause;
      $rose(resp_low) |-> pend_q;
   endproperty
   property p_resp_bound;
      $fell(transfer_start_n) |-> ##[1:400] resp_low;
   endproperty
   property p_strb_len;
      $fell(transfer_start_n) |-> !transfer_start_n[*8] ##1 transfer_start_n;
   endproperty
   property p_one_at_time;
      $fell(transfer_start_n) |-> !pend_q;
   endproperty
   property p_addr_hold;
      !transfer_start_n && !$past(transfer_start_n) |-> $stable(host_addr_in);
   endproperty
   property p_oe_excl;
      !(data_m2d_oe && data_d2m_oe);
   endproperty
   property p_rd_with_ack;
      data_d2m_oe |-> !transfer_ack_n;
   endproperty
   a_one_resp: assert property (p_one_resp) else $error("two responses at once");
   a_resp_len: assert property (p_resp_len) else $error("response width wrong");
   a_resp_cause: assert property (p_resp_cause) else $error("response unasked");
   a_resp_bound: assert property (p_resp_bound) else $error("no response");
   a_strb_len: assert property (p_strb_len) else $error("strobe width wrong");
   a_one_at_time: assert property (p_one_at_time) else $error("strobe too early");
   a_addr_hold: assert property (p_addr_hold) else $error("address moved");
   a_oe_excl: assert property (p_oe_excl) else $error("data bus contention");
   a_rd_with_ack: assert property (p_rd_with_ack) else $error("read data stray");
   c_ack: cover property ($fell(transfer_ack_n));
   c_err: cover property ($fell(transfer_error_ack_n));
   c_retry: cover property ($fell(transfer_retry_n));
endmodule
`default_nettype wire

// *** dv/config_port_and_host_bus_if_tb.sv ***
// Testbench joining the master and device ends of the host port link
`timescale 1ns/1ps
`default_nettype none
module config_port_and_host_bus_if_tb;
   logic        core_clk_in = 1'b0;
   logic        reset_n_in = 1'b0;
   logic        reinit_in = 1'b0, serial_cfg_cmd_in = 1'b0, dedicated_start_in = 1'b0;
   logic        sb_done_in = 1'b0, sb_err_in = 1'b0, sb_busy_in = 1'b0;
   logic [31:0] sb_rdata_in = 32'h0;
   logic [3:0]  sb_rpar_in = 4'h0;
   logic        req_in = 1'b0, write_in = 1'b0;
   logic [31:0] addr_in = 32'h0;
   logic [15:0] wdata_in = 16'h0;
   logic        dual_pins_gpio_out, port_locked_out, sb_req_out, sb_write_out;
   logic [1:0]  active_port_out, resp_out;
   logic [17:0] sb_addr_out;
   logic [31:0] sb_wdata_out;
   logic [3:0]  sb_wpar_out;
   logic        busy_out, done_out, par_ok_out;
   logic [15:0] rdata_out;
   int          n_errors = 0;
   int          num_checks = 0;
   always #10 core_clk_in = ~core_clk_in;
   hcp_link_if hcp_link_if_i ();
   hcp_device_port hcp_device_port_i (.core_clk_in(core_clk_in), .reset_n_in(reset_n_in),
      .link(hcp_link_if_i.device), .reinit_in(reinit_in),
      .serial_cfg_cmd_in(serial_cfg_cmd_in), .dedicated_start_in(dedicated_start_in),
      .dual_pins_gpio_out(dual_pins_gpio_out), .active_port_out(active_port_out),
      .port_locked_out(port_locked_out), .sb_req_out(sb_req_out),
      .sb_write_out(sb_write_out), .sb_addr_out(sb_addr_out), .sb_wdata_out(sb_wdata_out),
      .sb_wpar_out(sb_wpar_out), .sb_done_in(sb_done_in), .sb_err_in(sb_err_in),
      .sb_busy_in(sb_busy_in), .sb_rdata_in(sb_rdata_in), .sb_rpar_in(sb_rpar_in));
   hcp_master_port hcp_master_port_i (.core_clk_in(core_clk_in), .reset_n_in(reset_n_in),
      .link(hcp_link_if_i.master), .req_in(req_in), .write_in(write_in),
      .addr_in(addr_in), .wdata_in(wdata_in), .busy_out(busy_out), .done_out(done_out),
      .resp_out(resp_out), .rdata_out(rdata_out), .par_ok_out(par_ok_out));
   hcp_link_chk hcp_link_chk_i (.core_clk_in(core_clk_in), .reset_n_in(reset_n_in),
      .transfer_start_n(hcp_link_if_i.transfer_start_n),
      .host_addr_in(hcp_link_if_i.host_addr_in), .data_m2d_oe(hcp_link_if_i.data_m2d_oe),
      .data_d2m_oe(hcp_link_if_i.data_d2m_oe), .transfer_ack_n(hcp_link_if_i.transfer_ack_n),
      .transfer_error_ack_n(hcp_link_if_i.transfer_error_ack_n),
      .transfer_retry_n(hcp_link_if_i.transfer_retry_n));
   // =========================================
   // Helper tasks
   task automatic step();
      @(posedge core_clk_in);
      #1;
   endtask
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
      end
   endtask
   task automatic summarize();
      $display("Checks %0d, mismatches %0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   task automatic port_chk(input logic [1:0] p, input logic lk);
      chk(active_port_out, p);
      chk(port_locked_out, lk);
      chk(dual_pins_gpio_out, p != hcp_pkg::PORT_DEDICATED);
   endtask
   // Mode 0 done, 1 error, 2 busy, 3 refused without system bus request
   task automatic xfer(input logic wr, input logic [31:0] a, input logic [15:0] wd,
                       input int mode, input logic [1:0] er);
      int   i;
      logic seen;
      seen = 1'b0;
      write_in = wr;
      addr_in = a;
      wdata_in = wd;
      req_in = 1'b1;
      step();
      req_in = 1'b0;
      chk(busy_out, 1'b1);
      for (i = 0; i < 400 && done_out !== 1'b1; i++) begin
         if (sb_req_out === 1'b1) begin
            seen = 1'b1;
            chk(sb_addr_out, a[31:14]);
            chk(sb_write_out, wr);
            if (wr) begin
               chk(sb_wdata_out[15:0], wd);
               chk(sb_wpar_out[1:0], {^wd[15:8], ^wd[7:0]});
            end
            step();
            step();
            sb_done_in = (mode == 0);
            sb_err_in = (mode == 1);
            sb_busy_in = (mode == 2);
            sb_rdata_in = {16'h0, wd};
            sb_rpar_in = {2'h0, ^wd[15:8], ^wd[7:0]};
            step();
            sb_done_in = 1'b0;
            sb_err_in = 1'b0;
            sb_busy_in = 1'b0;
         end
         step();
      end
      chk(done_out, 1'b1);
      chk(busy_out, 1'b0);
      chk(resp_out, er);
      chk(seen, mode != 3);
      if (!wr && mode == 0) begin
         chk(rdata_out, wd);
         chk(par_ok_out, 1'b1);
      end
      if (done_out !== 1'b1) begin
         summarize();
      end
      repeat (24) step();
   endtask
   // =========================================
   // Main sequence
   initial begin
      repeat (10) step();
      reset_n_in = 1'b1;
      port_chk(hcp_pkg::PORT_DEDICATED, 1'b0);
      $display("Test reset done");
      xfer(1'b1, 32'hFFFFC000, 16'hA5C3, 0, hcp_pkg::RESP_ACK);
      port_chk(hcp_pkg::PORT_HOST, 1'b1);
      xfer(1'b0, 32'h00024000, 16'h3C81, 0, hcp_pkg::RESP_ACK);
      xfer(1'b1, 32'h12340000, 16'h00FF, 1, hcp_pkg::RESP_ERR);
      xfer(1'b0, 32'h80004000, 16'h7E01, 2, hcp_pkg::RESP_RETRY);
      serial_cfg_cmd_in = 1'b1;
      step();
      serial_cfg_cmd_in = 1'b0;
      step();
      port_chk(hcp_pkg::PORT_HOST, 1'b1);
      $display("Test host transfers done");
      reinit_in = 1'b1;
      step();
      reinit_in = 1'b0;
      step();
      port_chk(hcp_pkg::PORT_DEDICATED, 1'b0);
      serial_cfg_cmd_in = 1'b1;
      step();
      serial_cfg_cmd_in = 1'b0;
      step();
      port_chk(hcp_pkg::PORT_SERIAL, 1'b1);
      xfer(1'b1, 32'h00008000, 16'h1234, 3, hcp_pkg::RESP_RETRY);
      reinit_in = 1'b1;
      step();
      reinit_in = 1'b0;
      dedicated_start_in = 1'b1;
      step();
      dedicated_start_in = 1'b0;
      step();
      port_chk(hcp_pkg::PORT_DEDICATED, 1'b1);
      xfer(1'b0, 32'h00004000, 16'h5555, 3, hcp_pkg::RESP_RETRY);
      $display("Test port lock done");
      summarize();
   end
endmodule
`default_nettype wire
